// File: logic/pts_consts.vh
// Purpose: Shared constants for the PCI target and configuration space block
// Assumes: Offsets are configuration byte offsets; bit positions are within a dword
// Notes:   Identity values are parameters
`ifndef PTS_CONSTS_VH
`define PTS_CONSTS_VH

// ==========================================================================
// Bus command codes
`define PTS_CMD_MEM_READ 4'h6
`define PTS_CMD_MEM_WRITE 4'h7
`define PTS_CMD_CFG_READ 4'hA
`define PTS_CMD_CFG_WRITE 4'hB
`define PTS_CMD_MEM_READ_MULT 4'hC
`define PTS_CMD_MEM_READ_LINE 4'hE
`define PTS_CMD_MEM_WRITE_INV 4'hF

// ==========================================================================
// Configuration offsets
`define PTS_OFS_IDENT 8'h00
`define PTS_OFS_STATUS_COMMAND 8'h04
`define PTS_OFS_CLASS_REV 8'h08
`define PTS_OFS_SELFTEST_HDR_LAT 8'h0C
`define PTS_OFS_BAR0 8'h10
`define PTS_OFS_BAR1 8'h14
`define PTS_OFS_SUBSYS_VIEW 8'h2C
`define PTS_OFS_UNLOCK 8'hE0
`define PTS_OFS_SUBSYS_LOAD 8'hFC

// ==========================================================================
// Field positions and fixed values
`define PTS_BIT_CMD_MEM_EN 1
`define PTS_BIT_CMD_BM_EN 2
`define PTS_BIT_STAT_DEVSEL_LO 25
`define PTS_BIT_STAT_RX_TABORT 28
`define PTS_BIT_STAT_RX_MABORT 29
`define PTS_BIT_LAT_LO 11
`define PTS_BAR0_LSB 12
`define PTS_BAR1_LSB 16
`define PTS_DEVSEL_MEDIUM 2'h1
`define PTS_CLASS_CODE 24'h040100
`define PTS_UNLOCK_KEY 16'h4281

// ==========================================================================
// Reset values and timing counts
`define PTS_RST_LATENCY 5'h00
`define PTS_RST_SUBSYS 32'h00000000
`define PTS_RST_UNLOCK 16'h0000
`define PTS_MABORT_CYCLES 3'h5

`endif

// File: logic/pts_cfg_regs.v
// Purpose: Type 0 configuration header storage and read mux
// Assumes: One write per data phase, active-low byte enables
// Notes:   Read data is combinational
`timescale 1ns/1ps
`include "pts_consts.vh"

module pts_cfg_regs #(
  parameter [15:0] DEVICE_IDENT = 16'h0ABC, // Arbitrary value
  parameter [15:0] VENDOR_IDENT = 16'h0DEF, // Arbitrary value
  parameter [7:0] REVISION = 8'h0A // Arbitrary value
) (
  input wire clock,
  input wire reset_n,
  input wire wr,
  input wire [7:2] addr,
  input wire [3:0] be_n,
  input wire [31:0] wdata,
  output reg [31:0] rdata,
  input wire rx_tabort,
  input wire rx_mabort,
  input wire ee_load,
  input wire [31:0] ee_ids,
  output reg mem_en,
  output reg bm_en,
  output reg [31:12] bar0,
  output reg [31:16] bar1
);

  reg st_tabort;
  reg st_mabort;
  reg [4:0] latency;
  reg [15:0] unlock_key;
  reg [31:0] subsys;
  wire unlocked;
  wire [31:0] wm;

  // Byte-lane merge of new data into the current dword
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] ben;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        merge[i*8 +: 8] = ben[i] ? old[i*8 +: 8] : nw[i*8 +: 8];
      end
    end
  endfunction

  assign unlocked = (unlock_key == `PTS_UNLOCK_KEY);
  assign wm = merge(rdata, wdata, be_n);

  // ==========================================================================
  // Read mux
  always @* begin
    rdata = 32'h00000000;
    case ({addr, 2'b00})
      `PTS_OFS_IDENT: rdata = {DEVICE_IDENT, VENDOR_IDENT};
      `PTS_OFS_STATUS_COMMAND: begin
        rdata[`PTS_BIT_STAT_DEVSEL_LO +: 2] = `PTS_DEVSEL_MEDIUM;
        rdata[`PTS_BIT_STAT_RX_TABORT] = st_tabort;
        rdata[`PTS_BIT_STAT_RX_MABORT] = st_mabort;
        rdata[`PTS_BIT_CMD_MEM_EN] = mem_en;
        rdata[`PTS_BIT_CMD_BM_EN] = bm_en;
      end
      `PTS_OFS_CLASS_REV: rdata = {`PTS_CLASS_CODE, REVISION};
      `PTS_OFS_SELFTEST_HDR_LAT: rdata[`PTS_BIT_LAT_LO +: 5] = latency;
      `PTS_OFS_BAR0: rdata[31:12] = bar0;
      `PTS_OFS_BAR1: rdata[31:16] = bar1;
      `PTS_OFS_SUBSYS_VIEW: rdata = subsys;
      `PTS_OFS_UNLOCK: rdata[15:0] = unlock_key;
      `PTS_OFS_SUBSYS_LOAD: rdata = subsys;
      default: rdata = 32'h00000000;
    endcase
  end

  // ==========================================================================
  // Writable fields, abort flags set wins over write-one clear
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mem_en <= 1'b0;
      bm_en <= 1'b0;
      st_tabort <= 1'b0;
      st_mabort <= 1'b0;
      latency <= `PTS_RST_LATENCY;
      bar0 <= 20'h00000;
      bar1 <= 16'h0000;
      unlock_key <= `PTS_RST_UNLOCK;
      subsys <= `PTS_RST_SUBSYS;
    end else begin
      st_tabort <= rx_tabort | (st_tabort &
        ~(wr && {addr, 2'b00} == `PTS_OFS_STATUS_COMMAND && !be_n[3] &&
          wdata[`PTS_BIT_STAT_RX_TABORT]));
      st_mabort <= rx_mabort | (st_mabort &
        ~(wr && {addr, 2'b00} == `PTS_OFS_STATUS_COMMAND && !be_n[3] &&
          wdata[`PTS_BIT_STAT_RX_MABORT]));
      if (ee_load) begin
        subsys <= ee_ids;
      end else if (wr && {addr, 2'b00} == `PTS_OFS_SUBSYS_LOAD && unlocked) begin
        subsys <= wm;
      end
      if (wr) begin
        case ({addr, 2'b00})
          `PTS_OFS_STATUS_COMMAND: begin
            mem_en <= wm[`PTS_BIT_CMD_MEM_EN];
            bm_en <= wm[`PTS_BIT_CMD_BM_EN];
          end
          `PTS_OFS_SELFTEST_HDR_LAT: latency <= wm[`PTS_BIT_LAT_LO +: 5];
          `PTS_OFS_BAR0: bar0 <= wm[31:12];
          `PTS_OFS_BAR1: bar1 <= wm[31:16];
          `PTS_OFS_UNLOCK: unlock_key <= wm[15:0];
          default: ;
        endcase
      end
    end
  end

endmodule

// File: logic/pts_pci_target.v
// Purpose: PCI target and single-phase DMA master with type 0 configuration space
// Assumes: Pins synchronous to clock; window reads answer
//          one cycle after the strobe
// Notes:   One data phase per access, then disconnect
//
// What this block does
// - Claims memory read, memory write, config read and write; aliases map onto them.
// - Never claims I/O, interrupt acknowledge, special cycle or dual address cycles.
// - As DMA master issues only plain memory read and memory write.
// - Never ends a targeted transaction with target abort.
// - Config accesses honour byte, word and dword byte enables.
// - Disconnects after the first data phase of every targeted access.
// - Standard header at 00h-44h; E0h unlock register always writable; E4h-FFh read-only by default.
// - E4h-FFh writable only while unlock register holds 4281h.
// - Subsystem_ident_load load from EEPROM or FCh write; shown at 2Ch.
// - Subsystem_ident_view fields read zero until loaded.
// - Device-select timing field is read-only medium.
// - Class code reads multimedia audio, interface zero.
// - Latency timer: upper five bits writable, reset zero, low three read zero.
// - Header type and self-test bytes read zero.
// - Device and vendor identifiers read-only at offset 00h.
// - First base register decodes 4 KB register window, bits 31-12 writable.
// - Second base register decodes 64 KB memory window, bits 31-16 writable.
`timescale 1ns/1ps
`include "pts_consts.vh"

module pts_pci_target (
  input wire clock,
  input wire reset_n,
  input wire [31:0] ad_in,
  output reg [31:0] ad_out,
  output reg ad_oe,
  input wire [3:0] cbe_n_in,
  output reg [3:0] cbe_n_out,
  output reg cbe_oe,
  output reg par_out,
  output reg par_oe,
  input wire frame_n_in,
  output reg frame_n_out,
  output reg frame_oe,
  input wire irdy_n_in,
  output reg irdy_n_out,
  output reg irdy_oe,
  input wire trdy_n_in,
  output reg trdy_n_out,
  output reg trdy_oe,
  input wire devsel_n_in,
  output reg devsel_n_out,
  output reg devsel_oe,
  input wire stop_n_in,
  output reg stop_n_out,
  output reg stop_oe,
  input wire idsel,
  output reg req_n,
  input wire gnt_n,
  input wire ee_load,
  input wire [31:0] ee_subsys_ids,
  output reg win_rd,
  output reg win_wr,
  output reg win_sel,
  output reg [15:2] win_addr,
  output reg [31:0] win_wdata,
  input wire [31:0] win_rdata,
  input wire dma_start,
  input wire dma_write,
  input wire [31:2] dma_addr,
  input wire [31:0] dma_wdata,
  output reg dma_busy,
  output reg dma_done,
  output reg dma_error,
  output reg [31:0] dma_rdata
);

  // Target states
  localparam [2:0] T_IDLE = 3'h0;
  localparam [2:0] T_DECODE = 3'h1;
  localparam [2:0] T_DEVSEL = 3'h2;
  localparam [2:0] T_DATA = 3'h3;
  localparam [2:0] T_STOP = 3'h4;
  localparam [2:0] T_TURN = 3'h5;
  // Master states
  localparam [2:0] M_IDLE = 3'h0;
  localparam [2:0] M_REQ = 3'h1;
  localparam [2:0] M_ADDR = 3'h2;
  localparam [2:0] M_DATA = 3'h3;
  localparam [2:0] M_TURN = 3'h4;

  reg [2:0] t_state;
  reg [2:0] m_state;
  reg bus_idle;
  reg t_write;
  reg t_cfg;
  reg [7:2] t_cfg_addr;
  reg m_write;
  reg [31:2] m_addr;
  reg [31:0] m_wdata;
  reg m_retry;
  reg [2:0] m_wait;
  reg rx_tabort;
  reg rx_mabort;
  wire [31:0] cfg_rdata;
  wire cfg_wr;
  wire mem_en;
  wire bm_en;
  wire [31:12] bar0;
  wire [31:16] bar1;
  wire addr_phase;
  wire [3:0] cmd;
  wire hit_reg;
  wire hit_mem;
  wire hit_cfg;
  wire claim;
  wire target_free;
  wire t_done;

  // Memory read family, aliases folded in
  function is_mem_read;
    input [3:0] c;
    begin
      is_mem_read = (c == `PTS_CMD_MEM_READ) || (c == `PTS_CMD_MEM_READ_MULT) ||
        (c == `PTS_CMD_MEM_READ_LINE);
    end
  endfunction

  // Memory write family, aliases folded in
  function is_mem_write;
    input [3:0] c;
    begin
      is_mem_write = (c == `PTS_CMD_MEM_WRITE) || (c == `PTS_CMD_MEM_WRITE_INV);
    end
  endfunction

  // ==========================================================================
  // Configuration header
  pts_cfg_regs u_cfg (
    .clock(clock),
    .reset_n(reset_n),
    .wr(cfg_wr),
    .addr(t_cfg_addr),
    .be_n(cbe_n_in),
    .wdata(ad_in),
    .rdata(cfg_rdata),
    .rx_tabort(rx_tabort),
    .rx_mabort(rx_mabort),
    .ee_load(ee_load),
    .ee_ids(ee_subsys_ids),
    .mem_en(mem_en),
    .bm_en(bm_en),
    .bar0(bar0),
    .bar1(bar1)
  );

  // ==========================================================================
  // Address phase decode
  assign addr_phase = !frame_n_in && bus_idle;
  assign cmd = cbe_n_in;
  // Target ignores its own master cycles
  assign target_free = (t_state == T_IDLE) && (m_state == M_IDLE || m_state == M_REQ);
  assign hit_reg = mem_en && (ad_in[31:12] == bar0);
  assign hit_mem = mem_en && (ad_in[31:16] == bar1);
  assign hit_cfg = idsel && ad_in[1:0] == 2'b00 &&
    (cmd == `PTS_CMD_CFG_READ || cmd == `PTS_CMD_CFG_WRITE);
  // Other command codes fall through unclaimed
  assign claim = addr_phase && target_free && (hit_cfg ||
    ((is_mem_read(cmd) || is_mem_write(cmd)) && (hit_reg || hit_mem)));
  assign t_done = (t_state == T_DATA) && !irdy_n_in;
  // Locked protected offsets still complete, the storage ignores them
  assign cfg_wr = t_done && t_cfg && t_write;

  // ==========================================================================
  // Pin drivers: one process, one driver per pin
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ad_out <= 32'h00000000;
      ad_oe <= 1'b0;
      cbe_n_out <= 4'hF;
      cbe_oe <= 1'b0;
      par_out <= 1'b0;
      par_oe <= 1'b0;
      frame_n_out <= 1'b1;
      frame_oe <= 1'b0;
      irdy_n_out <= 1'b1;
      irdy_oe <= 1'b0;
      trdy_n_out <= 1'b1;
      trdy_oe <= 1'b0;
      devsel_n_out <= 1'b1;
      devsel_oe <= 1'b0;
      stop_n_out <= 1'b1;
      stop_oe <= 1'b0;
      req_n <= 1'b1;
      bus_idle <= 1'b1;
      t_state <= T_IDLE;
      m_state <= M_IDLE;
      t_write <= 1'b0;
      t_cfg <= 1'b0;
      t_cfg_addr <= 6'h00;
      m_write <= 1'b0;
      m_addr <= 30'h00000000;
      m_wdata <= 32'h00000000;
      m_retry <= 1'b0;
      m_wait <= 3'h0;
      rx_tabort <= 1'b0;
      rx_mabort <= 1'b0;
      win_rd <= 1'b0;
      win_wr <= 1'b0;
      win_sel <= 1'b0;
      win_addr <= 14'h0000;
      win_wdata <= 32'h00000000;
      dma_busy <= 1'b0;
      dma_done <= 1'b0;
      dma_error <= 1'b0;
      dma_rdata <= 32'h00000000;
    end else begin
      bus_idle <= frame_n_in && irdy_n_in;
      win_rd <= 1'b0;
      win_wr <= 1'b0;
      dma_done <= 1'b0;
      rx_tabort <= 1'b0;
      rx_mabort <= 1'b0;
      // Parity trails the driven address or data by one cycle
      par_oe <= ad_oe;
      par_out <= ^{ad_out, (cbe_oe ? cbe_n_out : cbe_n_in)};

      // Target side
      case (t_state)
        T_IDLE: begin
          if (claim) begin
            t_write <= is_mem_write(cmd) || cmd == `PTS_CMD_CFG_WRITE;
            t_cfg <= hit_cfg;
            t_cfg_addr <= ad_in[7:2];
            win_sel <= !hit_cfg && !hit_reg;
            win_addr <= hit_reg ? {4'h0, ad_in[11:2]} : ad_in[15:2];
            win_rd <= !hit_cfg && is_mem_read(cmd);
            t_state <= T_DECODE;
          end
        end
        T_DECODE: begin
          // Medium decode timing
          devsel_n_out <= 1'b0;
          devsel_oe <= 1'b1;
          trdy_oe <= 1'b1;
          stop_oe <= 1'b1;
          ad_oe <= !t_write;
          t_state <= T_DEVSEL;
        end
        T_DEVSEL: begin
          // Ready with stop: disconnect
          trdy_n_out <= 1'b0;
          stop_n_out <= 1'b0;
          ad_out <= t_cfg ? cfg_rdata : win_rdata;
          t_state <= T_DATA;
        end
        T_DATA: begin
          if (!irdy_n_in) begin
            trdy_n_out <= 1'b1;
            ad_oe <= 1'b0;
            win_wr <= t_write && !t_cfg;
            win_wdata <= ad_in;
            if (!frame_n_in) begin
              t_state <= T_STOP;
            end else begin
              devsel_n_out <= 1'b1;
              stop_n_out <= 1'b1;
              t_state <= T_TURN;
            end
          end
        end
        T_STOP: begin
          // Hold stop until the master ends the frame; never a target abort
          if (frame_n_in) begin
            devsel_n_out <= 1'b1;
            stop_n_out <= 1'b1;
            t_state <= T_TURN;
          end
        end
        T_TURN: begin
          devsel_oe <= 1'b0;
          trdy_oe <= 1'b0;
          stop_oe <= 1'b0;
          t_state <= T_IDLE;
        end
        default: t_state <= T_IDLE;
      endcase

      // Master side
      case (m_state)
        M_IDLE: begin
          if (dma_start && bm_en) begin
            m_write <= dma_write;
            m_addr <= dma_addr;
            m_wdata <= dma_wdata;
            dma_busy <= 1'b1;
            dma_error <= 1'b0;
            req_n <= 1'b0;
            m_state <= M_REQ;
          end
        end
        M_REQ: begin
          if (!gnt_n && frame_n_in && irdy_n_in && t_state == T_IDLE) begin
            req_n <= 1'b1;
            frame_n_out <= 1'b0;
            frame_oe <= 1'b1;
            irdy_oe <= 1'b1;
            ad_out <= {m_addr, 2'b00};
            ad_oe <= 1'b1;
            cbe_n_out <= m_write ? `PTS_CMD_MEM_WRITE : `PTS_CMD_MEM_READ;
            cbe_oe <= 1'b1;
            m_state <= M_ADDR;
          end
        end
        M_ADDR: begin
          // Single data phase: frame drops as ready rises
          frame_n_out <= 1'b1;
          irdy_n_out <= 1'b0;
          cbe_n_out <= 4'h0;
          ad_out <= m_wdata;
          ad_oe <= m_write;
          m_wait <= 3'h0;
          m_state <= M_DATA;
        end
        M_DATA: begin
          m_wait <= m_wait + 3'h1;
          if (!devsel_n_in && !trdy_n_in) begin
            dma_rdata <= ad_in;
            dma_done <= 1'b1;
            m_retry <= 1'b0;
          end else if (!devsel_n_in && !stop_n_in) begin
            m_retry <= 1'b1;
          end else if (devsel_n_in && !stop_n_in && m_wait != 3'h0) begin
            rx_tabort <= 1'b1;
            dma_error <= 1'b1;
            dma_done <= 1'b1;
            m_retry <= 1'b0;
          end else if (devsel_n_in && m_wait == `PTS_MABORT_CYCLES) begin
            rx_mabort <= 1'b1;
            dma_error <= 1'b1;
            dma_done <= 1'b1;
            m_retry <= 1'b0;
          end
          if ((!devsel_n_in && (!trdy_n_in || !stop_n_in)) ||
              (devsel_n_in && !stop_n_in && m_wait != 3'h0) ||
              (devsel_n_in && m_wait == `PTS_MABORT_CYCLES)) begin
            irdy_n_out <= 1'b1;
            ad_oe <= 1'b0;
            cbe_oe <= 1'b0;
            cbe_n_out <= 4'hF;
            frame_oe <= 1'b0;
            m_state <= M_TURN;
          end
        end
        M_TURN: begin
          irdy_oe <= 1'b0;
          if (m_retry) begin
            req_n <= 1'b0;
            m_state <= M_REQ;
          end else begin
            dma_busy <= 1'b0;
            m_state <= M_IDLE;
          end
        end
        default: m_state <= M_IDLE;
      endcase
    end
  end

endmodule

// File: tb/pts_props.sv
// Purpose: Pin protocol checks
// Assumes: Rising-edge sampling
// Notes:   Bound below
`timescale 1ns/1ps
// ========
// Checker
module pts_props (
  input wire clock,
  input wire reset_n,
  input wire [31:0] ad_in,
  input wire [3:0] cbe_n_in,
  input wire frame_n_in,
  input wire irdy_n_in,
  input wire idsel,
  input wire [31:0] ad_out,
  input wire [3:0] cbe_n_out,
  input wire cbe_oe,
  input wire frame_n_out,
  input wire frame_oe,
  input wire irdy_n_out,
  input wire trdy_n_out,
  input wire trdy_oe,
  input wire devsel_n_out,
  input wire devsel_oe,
  input wire stop_n_out,
  input wire stop_oe,
  input wire win_rd,
  input wire [31:0] win_rdata
);
  reg idle_q;
  wire addr_ph;
  default clocking dclk @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  // Bus idle history for address phases
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      idle_q <= 1'h1;
    end else begin
      idle_q <= frame_n_in & irdy_n_in;
    end
  end
  assign addr_ph = !frame_n_in && idle_q && !frame_oe;
  property p_cfg_claim;
    addr_ph && cbe_n_in[3:1] == 3'h5 && idsel && ad_in[1:0] == 2'h0
      |-> ##2 devsel_oe && !devsel_n_out;
  endproperty
  a_cfg_claim: assert property (p_cfg_claim) else $error("cfg not claimed");
  property p_no_claim;
    addr_ph && cbe_n_in inside {4'h0, 4'h1, 4'h2, 4'h3, 4'hD} |-> ##1 (!devsel_oe)[*6];
  endproperty
  a_no_claim: assert property (p_no_claim) else $error("bad claim");
  property p_no_tabort;
    devsel_oe && stop_oe && !stop_n_out |-> !devsel_n_out;
  endproperty
  a_no_tabort: assert property (p_no_tabort) else $error("target abort");
  property p_disc;
    trdy_oe && !trdy_n_out |-> !stop_n_out && !devsel_n_out;
  endproperty
  a_disc: assert property (p_disc) else $error("no disconnect");
  property p_single;
    trdy_oe && !trdy_n_out && !irdy_n_in |=> !trdy_oe || trdy_n_out;
  endproperty
  a_single: assert property (p_single) else $error("second phase");
  property p_win_data;
    win_rd |-> ##2 trdy_oe && !trdy_n_out && ad_out == $past(win_rdata);
  endproperty
  a_win_data: assert property (p_win_data) else $error("window data");
  property p_dma_cmd;
    frame_oe && !frame_n_out |-> cbe_oe && (cbe_n_out == 4'h6 || cbe_n_out == 4'h7);
  endproperty
  a_dma_cmd: assert property (p_dma_cmd) else $error("master command");
  property p_dma_data;
    frame_oe && !frame_n_out |=> frame_n_out && !irdy_n_out && cbe_n_out == 4'h0;
  endproperty
  a_dma_data: assert property (p_dma_data) else $error("master data phase wrong");
endmodule
bind pts_pci_target pts_props u_props (
  .clock(clock), .reset_n(reset_n), .ad_in(ad_in), .cbe_n_in(cbe_n_in),
  .frame_n_in(frame_n_in), .irdy_n_in(irdy_n_in), .idsel(idsel), .ad_out(ad_out),
  .cbe_n_out(cbe_n_out), .cbe_oe(cbe_oe), .frame_n_out(frame_n_out), .frame_oe(frame_oe),
  .irdy_n_out(irdy_n_out), .trdy_n_out(trdy_n_out), .trdy_oe(trdy_oe),
  .devsel_n_out(devsel_n_out), .devsel_oe(devsel_oe), .stop_n_out(stop_n_out),
  .stop_oe(stop_oe), .win_rd(win_rd), .win_rdata(win_rdata)
);

// File: tb/pts_host_mem.sv
// Purpose: Host arbiter and one-word memory
// Assumes: Mode 0 answers at once, mode 1 with two wait states, mode 2 never
// Notes:   Answers only granted cycles
`timescale 1ns/1ps
// ========
// Memory model
module pts_host_mem (
  input wire clock,
  input wire reset_n,
  input wire [1:0] mode,
  input wire req_n,
  input wire frame_n,
  input wire irdy_n,
  input wire [3:0] cbe_n,
  input wire [31:0] ad,
  output reg gnt_n,
  output reg trdy_n,
  output reg devsel_n,
  output reg ad_oe,
  output reg [31:0] ad_o,
  output reg [3:0] cmd,
  output reg [31:0] word
);
  reg [1:0] st, wait_cnt;
  reg frame_q;
  // Grant, claim, wait, one data phase
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      gnt_n <= 1'h1;
      trdy_n <= 1'h1;
      devsel_n <= 1'h1;
      ad_oe <= 1'h0;
      ad_o <= 32'h0;
      cmd <= 4'hF;
      word <= 32'h0;
      st <= 2'h0;
      wait_cnt <= 2'h0;
      frame_q <= 1'h1;
    end else begin
      gnt_n <= req_n;
      frame_q <= frame_n;
      case (st)
        2'h0: if (!frame_n && frame_q && !gnt_n) begin
          cmd <= cbe_n;
          wait_cnt <= mode[0] ? 2'h2 : 2'h0;
          st <= mode[1] ? 2'h0 : 2'h1;
        end
        2'h1: begin
          devsel_n <= 1'h0;
          if (wait_cnt == 2'h0) begin
            trdy_n <= 1'h0;
            ad_oe <= !cmd[0];
            ad_o <= word;
            st <= 2'h2;
          end else begin
            wait_cnt <= wait_cnt - 2'h1;
          end
        end
        default: if (!irdy_n) begin
          trdy_n <= 1'h1;
          devsel_n <= 1'h1;
          ad_oe <= 1'h0;
          if (cmd[0]) word <= ad;
          st <= 2'h0;
        end
      endcase
    end
  end
endmodule

// File: tb/testbench.sv
// Purpose: Bench for the PCI target
// Assumes: Released control lines pull up; released AD shows a moving pattern
// Notes:   Window reads answer next cycle
`timescale 1ns/1ps
// ========
// Bench
module testbench;
  reg clock = 1'h0, reset_n = 1'h0, tb_frame_n = 1'h1, tb_irdy_n = 1'h1, tb_ad_en = 1'h0;
  reg idsel = 1'h0, ee_load = 1'h0, dma_start = 1'h0, dma_write = 1'h0;
  reg [3:0] tb_cbe = 4'hF;
  reg [1:0] mode = 2'h0;
  reg [7:0] cyc = 8'h00;
  reg [31:2] dma_addr = 30'h40;
  reg [31:0] tb_ad = 32'h0, ee_ids = 32'h0, dma_wdata = 32'h0;
  reg [31:0] win_rdata = 32'h0, win_seen = 32'h0, rd, a;
  reg [13:0] ea;
  reg [3:0] c;
  integer mismatches = 0, checks = 0, i;
  wire [31:0] ad_out, win_wdata, dma_rdata, m_ad, m_word;
  wire [15:2] win_addr;
  wire [3:0] cbe_n_out, m_cmd;
  wire ad_oe, cbe_oe, frame_n_out, frame_oe, irdy_n_out, irdy_oe, trdy_n_out, trdy_oe;
  wire devsel_n_out, devsel_oe, stop_n_out, stop_oe, req_n, gnt_n, win_rd, win_wr, win_sel;
  wire dma_busy, dma_done, dma_error, m_trdy_n, m_devsel_n, m_ad_oe;
  // Wire levels; released AD shows a moving pattern
  wire frame_w = frame_oe ? frame_n_out : tb_frame_n;
  wire irdy_w = irdy_oe ? irdy_n_out : tb_irdy_n;
  wire trdy_w = trdy_oe ? trdy_n_out : m_trdy_n;
  wire devsel_w = devsel_oe ? devsel_n_out : m_devsel_n;
  wire stop_w = stop_oe ? stop_n_out : 1'h1;
  wire [3:0] cbe_w = cbe_oe ? cbe_n_out : tb_cbe;
  wire [31:0] ad_w = ad_oe ? ad_out : tb_ad_en ? tb_ad : m_ad_oe ? m_ad : {4{cyc}};
  pts_pci_target u_dut (.clock(clock), .reset_n(reset_n), .ad_in(ad_w), .ad_out(ad_out),
    .ad_oe(ad_oe), .cbe_n_in(cbe_w), .cbe_n_out(cbe_n_out), .cbe_oe(cbe_oe), .par_out(),
    .par_oe(), .frame_n_in(frame_w), .frame_n_out(frame_n_out), .frame_oe(frame_oe),
    .irdy_n_in(irdy_w), .irdy_n_out(irdy_n_out), .irdy_oe(irdy_oe), .trdy_n_in(trdy_w),
    .trdy_n_out(trdy_n_out), .trdy_oe(trdy_oe), .devsel_n_in(devsel_w),
    .devsel_n_out(devsel_n_out), .devsel_oe(devsel_oe), .stop_n_in(stop_w),
    .stop_n_out(stop_n_out), .stop_oe(stop_oe), .idsel(idsel), .req_n(req_n), .gnt_n(gnt_n),
    .ee_load(ee_load), .ee_subsys_ids(ee_ids), .win_rd(win_rd), .win_wr(win_wr),
    .win_sel(win_sel), .win_addr(win_addr), .win_wdata(win_wdata), .win_rdata(win_rdata),
    .dma_start(dma_start), .dma_write(dma_write), .dma_addr(dma_addr),
    .dma_wdata(dma_wdata), .dma_busy(dma_busy), .dma_done(dma_done),
    .dma_error(dma_error), .dma_rdata(dma_rdata));
  pts_host_mem u_mem (.clock(clock), .reset_n(reset_n), .mode(mode), .req_n(req_n),
    .frame_n(frame_w), .irdy_n(irdy_w), .cbe_n(cbe_w), .ad(ad_w), .gnt_n(gnt_n),
    .trdy_n(m_trdy_n), .devsel_n(m_devsel_n), .ad_oe(m_ad_oe), .ad_o(m_ad), .cmd(m_cmd),
    .word(m_word));
  always #2 clock = ~clock;
  // Window back end
  always @(posedge clock) begin
    cyc <= cyc + 8'h01;
    if (win_rd) win_rdata <= {win_sel, 1'h0, win_addr, 16'h5A5A};
    if (win_wr) win_seen <= win_wdata ^ {win_sel, 1'h0, win_addr, 16'h0};
  end
  task chk(input [8*10-1:0] name, input [31:0] exp, input [31:0] got);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("BAD %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  // One single-phase host cycle
  task acc(input [3:0] cmd, input [31:0] ad, input [3:0] be, input [31:0] wd,
      input claim);
    integer n;
    reg got;
    begin
      got = 1'h0;
      @(negedge clock);
      tb_frame_n = 1'h0;
      tb_ad_en = 1'h1;
      tb_ad = ad;
      tb_cbe = cmd;
      idsel = (cmd[3:1] == 3'h5);
      @(negedge clock);
      tb_frame_n = 1'h1;
      tb_irdy_n = 1'h0;
      tb_ad = wd;
      tb_ad_en = cmd[0];
      tb_cbe = be;
      idsel = 1'h0;
      for (n = 0; n < 8 && !got; n = n + 1) begin
        @(posedge clock);
        if (trdy_w === 1'h0) begin
          got = 1'h1;
          rd = ad_w;
          chk("stop", 32'h0, {31'h0, stop_w});
        end
      end
      @(negedge clock);
      tb_irdy_n = 1'h1;
      tb_ad_en = 1'h0;
      tb_cbe = 4'hF;
      repeat (3) @(negedge clock);
      chk("claim", {31'h0, claim}, {31'h0, got});
    end
  endtask
  task cw(input [7:0] o, input [3:0] be, input [31:0] d);
    acc(4'hB, {24'h0, o}, be, d, 1'h1);
  endtask
  task cr(input [7:0] o, input [31:0] e);
    begin
      acc(4'hA, {24'h0, o}, 4'h0, 32'h0, 1'h1);
      chk("cfg", e, rd);
    end
  endtask
  task dma(input wr, input [31:0] d, input err);
    integer n;
    begin
      @(negedge clock);
      dma_start = 1'h1;
      dma_write = wr;
      dma_wdata = d;
      @(negedge clock);
      dma_start = 1'h0;
      for (n = 0; n < 60 && dma_done !== 1'h1; n = n + 1) @(posedge clock);
      chk("dma done", 32'h1, {31'h0, dma_done});
      chk("dma err", {31'h0, err}, {31'h0, dma_error});
      repeat (3) @(negedge clock);
      chk("dma busy", 32'h0, {31'h0, dma_busy});
    end
  endtask
  task final_report;
    begin
      if (mismatches == 0 && checks > 0) begin
        $display("Testbench passed");
      end else begin
        $display("Testbench failed");
      end
      $finish;
    end
  endtask
  // Watchdog
  initial begin
    #60000;
    mismatches = mismatches + 1;
    final_report;
  end
  // Tests
  initial begin
    repeat (12) @(negedge clock);
    reset_n = 1'h1;
    repeat (2) @(negedge clock);
    cr(8'h00, 32'h0ABC0DEF);
    cr(8'h08, {24'h040100, 8'h0A});
    cr(8'h0C, 32'h0);
    cr(8'h04, 32'h02000000);
    cr(8'h2C, 32'h0);
    cw(8'h04, 4'h0, 32'hFFFFFFFF);
    cr(8'h04, 32'h02000006);
    cw(8'h0C, 4'hB, 32'hFFFFFFFF);
    cr(8'h0C, 32'h0);
    cw(8'h0C, 4'hD, 32'hFFFFFFFF);
    cr(8'h0C, 32'h0000F800);
    cw(8'h10, 4'h0, 32'hFFFFFFFF);
    cr(8'h10, 32'hFFFFF000);
    cw(8'h14, 4'h0, 32'hFFFFFFFF);
    cr(8'h14, 32'hFFFF0000);
    cw(8'h10, 4'h0, 32'h12345000);
    cw(8'h14, 4'h0, 32'h67890000);
    cw(8'hFC, 4'h0, 32'h11223344);
    cr(8'hFC, 32'h0);
    cr(8'h2C, 32'h0);
    cw(8'hE0, 4'h0, 32'h00004281);
    cr(8'hE0, 32'h00004281);
    cw(8'hFC, 4'h0, 32'h11223344);
    cr(8'h2C, 32'h11223344);
    cw(8'hE0, 4'h0, 32'h0);
    cw(8'hFC, 4'h0, 32'h55667788);
    cr(8'h2C, 32'h11223344);
    cr(8'hE4, 32'h0);
    @(negedge clock);
    ee_ids = 32'h99AABBCC;
    ee_load = 1'h1;
    @(negedge clock);
    ee_load = 1'h0;
    cr(8'h2C, 32'h99AABBCC);
    for (i = 0; i < 5; i = i + 1) begin
      c = 20'hEC6F7 >> (4 * i);
      a = i[0] ? 32'h67891230 : 32'h12345024;
      ea = i[0] ? a[15:2] : {4'h0, a[11:2]};
      acc(c, a, 4'h0, 32'hC0DE0000 + i, 1'h1);
      if (c[0]) begin
        chk("win wr", (32'hC0DE0000 + i) ^ {i[0], 1'h0, ea, 16'h0}, win_seen);
      end else begin
        chk("win rd", {i[0], 1'h0, ea, 16'h5A5A}, rd);
      end
    end
    for (i = 0; i < 5; i = i + 1) begin
      c = 20'hD3210 >> (4 * i);
      acc(c, 32'h12345024, 4'h0, 32'h0, 1'h0);
    end
    dma(1'h1, 32'hA5A50001, 1'h0);
    chk("mem cmd", 32'h7, {28'h0, m_cmd});
    chk("mem word", 32'hA5A50001, m_word);
    mode = 2'h1;
    dma(1'h0, 32'h0, 1'h0);
    chk("mem cmd", 32'h6, {28'h0, m_cmd});
    chk("dma rd", 32'hA5A50001, dma_rdata);
    mode = 2'h2;
    dma(1'h0, 32'h0, 1'h1);
    cr(8'h04, 32'h22000006);
    cw(8'h04, 4'h7, 32'h20000000);
    cr(8'h04, 32'h02000006);
    final_report;
  end
endmodule
